// ==== verilog/csfbs_defs.vh ====
`ifndef CSFBS_DEFS_VH
`define CSFBS_DEFS_VH

// ----------------------------------------
// register decode
// ----------------------------------------
`define CSFBS_STATUS_OFS 7'h03
`define CSFBS_ADDR_W 9

// ----------------------------------------
// field positions
// ----------------------------------------
`define CSFBS_IBANK_BIT 7
`define CSFBS_RPH_BIT 6
`define CSFBS_RPL_BIT 5
`define CSFBS_WDX_BIT 4
`define CSFBS_SLP_BIT 3
`define CSFBS_Z_BIT 2
`define CSFBS_NIB_BIT 1
`define CSFBS_C_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSFBS_RST_BANK 3'h0
`define CSFBS_RST_CAUSE 2'h3
`define CSFBS_RST_ARITH 3'h0

// ----------------------------------------
// alu operations
// ----------------------------------------
`define CSFBS_OP_W 4
`define CSFBS_OP_PASS 4'h0
`define CSFBS_OP_ADD 4'h1
`define CSFBS_OP_SUB 4'h2
`define CSFBS_OP_AND 4'h3
`define CSFBS_OP_IOR 4'h4
`define CSFBS_OP_XOR 4'h5
`define CSFBS_OP_COM 4'h6
`define CSFBS_OP_INC 4'h7
`define CSFBS_OP_DEC 4'h8
`define CSFBS_OP_ROR 4'h9
`define CSFBS_OP_ROL 4'ha
`define CSFBS_OP_SWAP 4'hb
`define CSFBS_OP_CLR 4'hc

// ----------------------------------------
// flag update classes
// ----------------------------------------
`define CSFBS_FU_W 2
`define CSFBS_FU_NONE 2'h0
`define CSFBS_FU_Z 2'h1
`define CSFBS_FU_ZDC 2'h2
`define CSFBS_FU_C 2'h3

`endif

// ==== verilog/csfbs_alu.v ====
`timescale 1ns/100ps
`include "csfbs_defs.vh"

// combinational alu producing result and flag candidates
module csfbs_alu #(
    parameter W = 8
) (
    input wire [`CSFBS_OP_W-1:0] op,
    input wire [W-1:0] opa,
    input wire [W-1:0] opb,
    input wire carry_in,
    output reg [W-1:0] res,
    output reg c_out,
    output reg dc_out
);
    reg [W:0] sum;
    reg [4:0] nib;
    reg [W-1:0] addend;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    // subtract is opa + ~opb + 1, so carry high means no borrow
    always @* begin
        sum = {(W+1){1'b0}};
        nib = 5'h00;
        res = opa;
        c_out = carry_in;
        dc_out = 1'b0;
        addend = (op == `CSFBS_OP_SUB) ? ~opb : opb;
        case (op)
            `CSFBS_OP_ADD, `CSFBS_OP_SUB: begin
                sum = {1'b0, opa} + {1'b0, addend} + {{W{1'b0}}, (op == `CSFBS_OP_SUB)};
                nib = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, (op == `CSFBS_OP_SUB)};
                res = sum[W-1:0];
                c_out = sum[W];
                dc_out = nib[4];
            end
            `CSFBS_OP_AND: res = opa & opb;
            `CSFBS_OP_IOR: res = opa | opb;
            `CSFBS_OP_XOR: res = opa ^ opb;
            `CSFBS_OP_COM: res = ~opa;
            `CSFBS_OP_INC: res = opa + {{(W-1){1'b0}}, 1'b1};
            `CSFBS_OP_DEC: res = opa - {{(W-1){1'b0}}, 1'b1};
            `CSFBS_OP_ROR: begin
                res = {carry_in, opa[W-1:1]};
                c_out = opa[0];
            end
            `CSFBS_OP_ROL: begin
                res = {opa[W-2:0], carry_in};
                c_out = opa[W-1];
            end
            `CSFBS_OP_SWAP: res = {opa[3:0], opa[W-1:4]};
            `CSFBS_OP_CLR: res = {W{1'b0}};
            default: res = opa;
        endcase
    end
endmodule

// ==== verilog/csfbs_status.v ====
// Contract
// - one status register at four mirrors
// - status writable as any instruction destination
// - flag-updating op blocks data write to flags
// - instruction writes to reset-cause bits ignored
// - clear clears bank bits, sets zero
// - borrow flags inverted during subtract
// - bit 7 picks indirect bank pair
// - bits 6-5 pick direct bank
// - timeout flag set by events, cleared on expiry
// - sleep flag set by kick, cleared by sleep
// - zero flag follows result zero
// - digit carry from low nibble on add/sub
// - carry from msb on add/sub
// - subtract adds two's complement
// - rotates load carry from shifted bit
`timescale 1ns/100ps
`include "csfbs_defs.vh"

module csfbs_status #(
    parameter W = 8
) (
    input wire sys_clk,
    input wire rst_n,
    input wire exec_en,
    input wire [`CSFBS_OP_W-1:0] alu_op,
    input wire [`CSFBS_FU_W-1:0] flag_upd,
    input wire [W-1:0] opnd_a,
    input wire [W-1:0] opnd_b,
    input wire wr_en,
    input wire [`CSFBS_ADDR_W-1:0] wr_addr,
    input wire [`CSFBS_ADDR_W-1:0] rd_addr,
    input wire watchdog_kick_instr,
    input wire sleep_instr,
    input wire watchdog_timeout,
    output reg [W-1:0] status_q,
    output reg [W-1:0] alu_res_q,
    output reg rd_hit_q,
    output reg [1:0] direct_bank_q,
    output reg indirect_bank_bit_q
);
    wire [W-1:0] res;
    wire c_new;
    wire dc_new;
    wire wr_hit;
    wire rd_hit;
    wire z_new;
    reg [W-1:0] status_d;

    // ----------------------------------------
    // alu
    // ----------------------------------------
    csfbs_alu #(
        .W(W)
    ) u_alu (
        .op(alu_op),
        .opa(opnd_a),
        .opb(opnd_b),
        .carry_in(status_q[`CSFBS_C_BIT]),
        .res(res),
        .c_out(c_new),
        .dc_out(dc_new)
    );

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // mirrored decode ignores bank bits
    assign wr_hit = wr_en && exec_en && (wr_addr[6:0] == `CSFBS_STATUS_OFS);
    assign rd_hit = (rd_addr[6:0] == `CSFBS_STATUS_OFS);
    assign z_new = (res == {W{1'b0}});

    // ----------------------------------------
    // next status
    // ----------------------------------------
    // data write first, then flag logic overrides, then hardware events
    always @* begin
        status_d = status_q;
        if (wr_hit) begin
            status_d[7:5] = res[7:5];
            status_d[2:0] = res[2:0];
            status_d[4:3] = status_q[4:3];
        end
        if (exec_en) begin
            case (flag_upd)
                `CSFBS_FU_Z: begin
                    status_d[`CSFBS_Z_BIT] = z_new;
                    if (wr_hit) begin
                        status_d[1:0] = status_q[1:0];
                    end
                end
                `CSFBS_FU_ZDC: begin
                    status_d[`CSFBS_Z_BIT] = z_new;
                    status_d[`CSFBS_NIB_BIT] = dc_new;
                    status_d[`CSFBS_C_BIT] = c_new;
                end
                `CSFBS_FU_C: begin
                    status_d[`CSFBS_C_BIT] = c_new;
                    if (wr_hit) begin
                        status_d[2:1] = status_q[2:1];
                    end
                end
                default: begin
                end
            endcase
        end
        if (watchdog_kick_instr || sleep_instr) begin
            status_d[`CSFBS_WDX_BIT] = 1'b1;
        end
        if (watchdog_timeout) begin
            status_d[`CSFBS_WDX_BIT] = 1'b0;
        end
        if (watchdog_kick_instr) begin
            status_d[`CSFBS_SLP_BIT] = 1'b1;
        end
        if (sleep_instr) begin
            status_d[`CSFBS_SLP_BIT] = 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // arithmetic flags are left 0 at reset; software must not rely on them
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            status_q <= {`CSFBS_RST_BANK, `CSFBS_RST_CAUSE, `CSFBS_RST_ARITH};
            alu_res_q <= {W{1'b0}};
            rd_hit_q <= 1'b0;
            direct_bank_q <= 2'h0;
            indirect_bank_bit_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (exec_en) begin
                alu_res_q <= res;
            end
            rd_hit_q <= rd_hit;
            direct_bank_q <= status_d[`CSFBS_RPH_BIT:`CSFBS_RPL_BIT];
            indirect_bank_bit_q <= status_d[`CSFBS_IBANK_BIT];
        end
    end
endmodule

// ==== tb/csfbs_status_sva.sv ====
`timescale 1ns/100ps
// ----
// status register checker
// ----
module csfbs_status_sva (
    input wire sys_clk,
    input wire rst_n,
    input wire exec_en,
    input wire [3:0] alu_op,
    input wire [1:0] flag_upd,
    input wire [7:0] opnd_a,
    input wire [7:0] opnd_b,
    input wire wr_en,
    input wire [8:0] wr_addr,
    input wire [8:0] rd_addr,
    input wire watchdog_kick_instr,
    input wire sleep_instr,
    input wire watchdog_timeout,
    input wire [7:0] status_q,
    input wire [7:0] alu_res_q,
    input wire rd_hit_q,
    input wire [1:0] direct_bank_q,
    input wire indirect_bank_bit_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // reset has no disable so the reset value itself is seen
    property p_rst;
        disable iff (1'b0) !rst_n |=> status_q[7:3] == 5'h03;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset value");
    property p_bank;
        {indirect_bank_bit_q, direct_bank_q} == status_q[7:5];
    endproperty
    a_bank: assert property (p_bank) else $error("bank outputs differ");
    property p_rd;
        $past(rst_n) |-> rd_hit_q == ($past(rd_addr[6:0]) == 7'h03);
    endproperty
    a_rd: assert property (p_rd) else $error("mirror decode wrong");
    property p_tmo;
        watchdog_timeout |=> !status_q[4];
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout flag kept");
    // a timeout in the same cycle wins bit 4, so it is left out here
    property p_sleep;
        sleep_instr && !watchdog_timeout |=> !status_q[3] ##0 status_q[4];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_kick;
        watchdog_kick_instr && !sleep_instr && !watchdog_timeout |=> status_q[4:3] == 2'h3;
    endproperty
    a_kick: assert property (p_kick) else $error("kick flags wrong");
    property p_nowr;
        exec_en && wr_en && wr_addr[6:0] == 7'h03 && !(watchdog_kick_instr || sleep_instr || watchdog_timeout)
            |=> $stable(status_q[4:3]);
    endproperty
    a_nowr: assert property (p_nowr) else $error("cause bits written");
    property p_z;
        exec_en && (flag_upd == 2'h1 || flag_upd == 2'h2) |=> status_q[2] == (alu_res_q == 8'h00);
    endproperty
    a_z: assert property (p_z) else $error("zero flag wrong");
    property p_sum;
        exec_en && alu_op == 4'h1 && flag_upd == 2'h2 |=> {status_q[0], alu_res_q} == $past({1'b0, opnd_a} + {1'b0, opnd_b});
    endproperty
    a_sum: assert property (p_sum) else $error("add carry wrong");
endmodule
bind csfbs_status csfbs_status_sva u_sva (.*);

// ==== tb/csfbs_exec_model.sv ====
`timescale 1ns/100ps
// execution unit: one op per call, driven off the falling edge
module csfbs_exec_model (
    input wire sys_clk,
    output reg exec_en,
    output reg [3:0] alu_op,
    output reg [1:0] flag_upd,
    output reg [7:0] opnd_a,
    output reg [7:0] opnd_b,
    output reg wr_en,
    output reg [8:0] wr_addr,
    output reg [8:0] rd_addr,
    output reg [2:0] evt
);
    // idle state, nothing requested before reset ends
    initial {exec_en, alu_op, flag_upd, opnd_a, opnd_b, wr_en, wr_addr, rd_addr, evt} = 45'h0;
    // operands stay put after the pulse, only strobes drop
    task issue(input [3:0] op, input [1:0] fu, input [7:0] a, input [7:0] b, input [8:0] ad);
        begin
            @(negedge sys_clk);
            {exec_en, alu_op, flag_upd, opnd_a, opnd_b, wr_en, wr_addr, rd_addr} = {1'b1, op, fu, a, b, 1'b1, ad, ad};
            @(negedge sys_clk);
            {exec_en, wr_en} = 2'h0;
        end
    endtask
    // kick, sleep, timeout as one-cycle pulses
    task event_pulse(input [2:0] e);
        begin
            @(negedge sys_clk);
            evt = e;
            @(negedge sys_clk);
            evt = 3'h0;
        end
    endtask
endmodule

// ==== tb/csfbs_status_tb_top.sv ====
`timescale 1ns/100ps
module csfbs_status_tb_top;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    wire exec_en, wr_en, rd_hit_q, indirect_bank_bit_q;
    wire [3:0] alu_op;
    wire [2:0] evt;
    wire [1:0] flag_upd, direct_bank_q;
    wire [7:0] opnd_a, opnd_b, status_q, alu_res_q;
    wire [8:0] wr_addr, rd_addr;
    integer num_errors = 0;
    integer check_count = 0;
    integer i;
    reg [32:0] row [0:12];
    always #5 sys_clk = ~sys_clk;
    csfbs_exec_model u_exec (.sys_clk(sys_clk), .exec_en(exec_en), .alu_op(alu_op), .flag_upd(flag_upd),
        .opnd_a(opnd_a), .opnd_b(opnd_b), .wr_en(wr_en), .wr_addr(wr_addr), .rd_addr(rd_addr), .evt(evt));
    csfbs_status DUT (.sys_clk(sys_clk), .rst_n(rst_n), .exec_en(exec_en), .alu_op(alu_op), .flag_upd(flag_upd),
        .opnd_a(opnd_a), .opnd_b(opnd_b), .wr_en(wr_en), .wr_addr(wr_addr), .rd_addr(rd_addr),
        .watchdog_kick_instr(evt[2]), .sleep_instr(evt[1]), .watchdog_timeout(evt[0]), .status_q(status_q),
        .alu_res_q(alu_res_q), .rd_hit_q(rd_hit_q), .direct_bank_q(direct_bank_q),
        .indirect_bank_bit_q(indirect_bank_bit_q));
    task chk(input [7:0] exp, input [7:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    // watchdog: whole sequence needs well under 100 cycles
    initial begin
        #5000;
        num_errors = num_errors + 1;
        results;
    end
    // main sequence; rows are op, class, a, b, flags, result
    initial begin
        row[0] = {4'h1, 2'h2, 8'hff, 8'h01, 3'h7, 8'h00};
        row[1] = {4'h1, 2'h2, 8'h08, 8'h08, 3'h2, 8'h10};
        row[2] = {4'h2, 2'h2, 8'h05, 8'h03, 3'h3, 8'h02};
        row[3] = {4'h2, 2'h2, 8'h03, 8'h05, 3'h0, 8'hfe};
        row[4] = {4'h9, 2'h3, 8'h01, 8'h00, 3'h1, 8'h00};
        row[5] = {4'ha, 2'h3, 8'h7f, 8'h00, 3'h0, 8'hff};
        row[6] = {4'h3, 2'h1, 8'hf0, 8'h0f, 3'h4, 8'h00};
        row[7] = {4'h4, 2'h1, 8'hf0, 8'h0f, 3'h0, 8'hff};
        row[8] = {4'h5, 2'h1, 8'h5a, 8'h5a, 3'h4, 8'h00};
        row[9] = {4'h6, 2'h1, 8'h0f, 8'h00, 3'h0, 8'hf0};
        row[10] = {4'h7, 2'h1, 8'hff, 8'h00, 3'h4, 8'h00};
        row[11] = {4'hb, 2'h0, 8'h3c, 8'h00, 3'h4, 8'hc3};
        row[12] = {4'h8, 2'h1, 8'h02, 8'h00, 3'h0, 8'h01};
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        chk(8'h18, status_q);
        u_exec.event_pulse(3'h2);
        chk(8'h10, status_q);
        u_exec.issue(4'h0, 2'h0, 8'hff, 8'h00, 9'h183);
        chk(8'hf7, status_q);
        chk(8'h07, {5'h00, indirect_bank_bit_q, direct_bank_q});
        chk(8'h01, {7'h00, rd_hit_q});
        u_exec.event_pulse(3'h1);
        chk(8'he7, status_q);
        u_exec.issue(4'hc, 2'h1, 8'h00, 8'h00, 9'h003);
        chk(8'h07, status_q);
        u_exec.event_pulse(3'h4);
        chk(8'h1f, status_q);
        for (i = 0; i < 13; i = i + 1) begin
            u_exec.issue(row[i][32:29], row[i][28:27], row[i][26:19], row[i][18:11], 9'h020);
            chk({5'h03, row[i][10:8]}, status_q);
            chk(row[i][7:0], alu_res_q);
            chk(8'h00, {7'h00, rd_hit_q});
        end
        u_exec.issue(4'h1, 2'h2, 8'h03, 8'h04, 9'h103);
        chk(8'h18, status_q);
        results;
    end
endmodule
